// file: core/uvt_phase.sv
// One measuring element: start decision with hysteresis and delay timer
`timescale 1ns/1ps
module uvt_phase (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             enable,
    input  wire logic             tick,
    input  wire logic [15:0]      magnitude,
    input  uvt_pkg::uvt_cfg_t     cfg,
    output logic                  start_q,
    output logic                  trip
);

    logic        start_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // ==========================================
    // Thresholds in magnitude units
    wire [15:0] start_thr  = {cfg.start_pct, 8'h00};
    wire [15:0] block_thr  = {cfg.block_pct, 8'h00};
    wire [23:0] mag_x100   = 24'(magnitude) * 24'(uvt_pkg::PCT_BASE);
    wire [23:0] drop_thr   = 24'(start_thr) * 24'(uvt_pkg::PCT_BASE + 7'(cfg.ratio_pct));
    wire        below_st   = magnitude < start_thr;
    wire        above_blk  = magnitude > block_thr;
    wire        above_drop = mag_x100 > drop_thr;
    // Delay counts whole ticks past the setting so the full time is always served
    wire        expired    = cnt_q > cfg.delay_ms;

    // ==========================================
    // Start decision
    always_comb begin
        if (!enable) begin
            start_d = 1'b0; // R14
        end else if (!start_q) begin
            start_d = below_st && above_blk; // R1 R5
        end else begin
            start_d = above_blk && !above_drop; // R16 R5 R6
        end
    end

    // ==========================================
    // Delay timer, cleared whenever the element is not started
    assign cnt_d = !start_q ? 16'h0000 :
                   (tick && !expired) ? cnt_q + 16'h0001 : cnt_q; // R10 R16
    assign trip  = start_q && expired && !cfg.start_only; // R3 R8 R10

    always_ff @(posedge clk) begin
        if (!rstn) begin
            start_q <= 1'b0;
            cnt_q   <= 16'h0000;
        end else begin
            start_q <= start_d;
            cnt_q   <= cnt_d;
        end
    end

endmodule

// file: core/uvt_pkg.sv
// Package for the definite-time undervoltage trip block
// What this block does
// R1 - Phase starts when below start, above block
// R2 - General start when any phase starts
// R3 - Trip only after delay and trips enabled
// R4 - Start level 30 to 130 percent, default 90
// R5 - Below block level suppresses start; 0-20, default 10
// R6 - Drop-off ratio 1 to 10 percent, default 5
// R7 - Operation off, 1of3, 2of3, all; resets off
// R8 - Start-only bit defaults 0; 1 never trips
// R9 - Trip delay 50 to 60000 ms, default 100
// R10 - Per-phase timer raises phase trip at expiry
// R11 - Start and trip per phase or line pair
// R12 - Phase trips stay internal, only general published
// R13 - Medium voltage uses line-to-line magnitudes by default
// R14 - External block input disables the function
// R15 - General trip built from phase trips
// R16 - Start clears above start plus ratio; timer restarts
// R17 - General trip needs selected count; off keeps outputs low
package uvt_pkg;

    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned TICK_US         = 1000;
    localparam int unsigned CYCLES_PER_TICK = CLK_HZ / 1_000_000 * TICK_US;

    // ==========================================
    // Magnitude format: percent of nominal, 8 fraction bits
    localparam int unsigned MAG_W    = 16;
    localparam int unsigned MAG_FRAC = 8;
    localparam logic [6:0]  PCT_BASE = 7'd100;

    // ==========================================
    // Setting limits and reset values
    localparam logic [7:0]  START_MIN = 8'd30;
    localparam logic [7:0]  START_MAX = 8'd130;
    localparam logic [7:0]  START_RST = 8'd90;
    localparam logic [7:0]  BLOCK_MAX = 8'd20;
    localparam logic [7:0]  BLOCK_RST = 8'd10;
    localparam logic [3:0]  RATIO_MIN = 4'd1;
    localparam logic [3:0]  RATIO_MAX = 4'd10;
    localparam logic [3:0]  RATIO_RST = 4'd5;
    localparam logic [15:0] DELAY_MIN = 16'd50;
    localparam logic [15:0] DELAY_MAX = 16'd60000;
    localparam logic [15:0] DELAY_RST = 16'd100;
    localparam logic        SONLY_RST = 1'b0;
    localparam logic        LPAIR_RST = 1'b1;

    // ==========================================
    // Register offsets and fields
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LEVELS = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_ST = 8'h10;
    localparam logic [7:0] OFS_IRQ_MK = 8'h14;
    localparam int unsigned CTRL_OPER_LSB = 0;
    localparam int unsigned CTRL_SONLY    = 2;
    localparam int unsigned CTRL_LPAIR    = 3;
    localparam int unsigned LVL_START_LSB = 0;
    localparam int unsigned LVL_BLOCK_LSB = 8;
    localparam int unsigned LVL_RATIO_LSB = 16;
    localparam int unsigned IRQ_GS        = 0;
    localparam int unsigned IRQ_GT        = 1;
    localparam int unsigned IRQ_W         = 2;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        UVT_OFF,
        UVT_ONE,
        UVT_TWO,
        UVT_ALL
    } uvt_oper_t;

    typedef struct packed {
        uvt_oper_t   oper;
        logic        start_only;
        logic        line_pair;
        logic [7:0]  start_pct;
        logic [7:0]  block_pct;
        logic [3:0]  ratio_pct;
        logic [15:0] delay_ms;
    } uvt_cfg_t;

endpackage

// file: core/uvt_tick.sv
// Millisecond timebase pulse generator
`timescale 1ns/1ps
module uvt_tick #(
    parameter int unsigned CYCLES = uvt_pkg::CYCLES_PER_TICK
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    wire         wrap = (cnt_q == 16'(CYCLES - 1));

    assign cnt_d = wrap ? 16'h0000 : cnt_q + 16'h0001;
    assign tick  = wrap;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// file: core/uvt_top.sv
// Definite-time undervoltage trip: settings, decision logic, APB slave, interrupt
`timescale 1ns/1ps
module uvt_top #(
    parameter int unsigned TICK_CYCLES = uvt_pkg::CYCLES_PER_TICK
) (
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [15:0] PHASE_A_MAGNITUDE,
    input  wire logic [15:0] PHASE_B_MAGNITUDE,
    input  wire logic [15:0] PHASE_C_MAGNITUDE,
    input  wire logic        FUNCTION_BLOCK_IN,
    output logic             PHASE_A_START,
    output logic             PHASE_B_START,
    output logic             PHASE_C_START,
    output logic             GENERAL_START_OUT,
    output logic             GENERAL_TRIP_OUT,
    output logic             LINE_PAIR_MODE,
    output logic             IRQ
);

    // ==========================================
    // Settings registers
    uvt_pkg::uvt_oper_t oper_q;
    logic               sonly_q;
    logic               lpair_q;
    logic [7:0]         start_q;
    logic [7:0]         block_q;
    logic [3:0]         ratio_q;
    logic [15:0]        delay_q;
    logic [uvt_pkg::IRQ_W-1:0] irq_st_q;
    logic [uvt_pkg::IRQ_W-1:0] irq_st_d;
    logic [uvt_pkg::IRQ_W-1:0] irq_mk_q;
    logic [31:0]        rdata_q;
    logic               gstart_q;
    logic               gtrip_q;
    logic               gstart_d;
    logic               gtrip_d;
    uvt_pkg::uvt_cfg_t  cfg;
    logic               tick;
    logic [2:0]         ph_start;
    logic [2:0]         ph_trip;
    logic [15:0]        mags [3];

    // ==========================================
    // APB decode; the slave never waits
    wire setup    = PSEL && !PENABLE;
    wire access   = PSEL && PENABLE;
    wire wr       = access && PWRITE;
    wire hit_ctrl = PADDR == uvt_pkg::OFS_CTRL;
    wire hit_lvl  = PADDR == uvt_pkg::OFS_LEVELS;
    wire hit_dly  = PADDR == uvt_pkg::OFS_DELAY;
    wire hit_stat = PADDR == uvt_pkg::OFS_STATUS;
    wire hit_ist  = PADDR == uvt_pkg::OFS_IRQ_ST;
    wire hit_imk  = PADDR == uvt_pkg::OFS_IRQ_MK;
    wire mapped   = hit_ctrl || hit_lvl || hit_dly || hit_stat || hit_ist || hit_imk;

    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;
    assign PRDATA  = rdata_q;

    // ==========================================
    // Written values clamped into their legal ranges
    wire [7:0]  w_start = PWDATA[uvt_pkg::LVL_START_LSB +: 8];
    wire [7:0]  w_block = PWDATA[uvt_pkg::LVL_BLOCK_LSB +: 8];
    wire [3:0]  w_ratio = PWDATA[uvt_pkg::LVL_RATIO_LSB +: 4];
    wire [15:0] w_delay = PWDATA[15:0];
    wire [7:0]  c_start = (w_start < uvt_pkg::START_MIN) ? uvt_pkg::START_MIN :
                          (w_start > uvt_pkg::START_MAX) ? uvt_pkg::START_MAX : w_start; // R4
    wire [7:0]  c_block = (w_block > uvt_pkg::BLOCK_MAX) ? uvt_pkg::BLOCK_MAX : w_block; // R5
    wire [3:0]  c_ratio = (w_ratio < uvt_pkg::RATIO_MIN) ? uvt_pkg::RATIO_MIN :
                          (w_ratio > uvt_pkg::RATIO_MAX) ? uvt_pkg::RATIO_MAX : w_ratio; // R6
    wire [15:0] c_delay = (w_delay < uvt_pkg::DELAY_MIN) ? uvt_pkg::DELAY_MIN :
                          (w_delay > uvt_pkg::DELAY_MAX) ? uvt_pkg::DELAY_MAX : w_delay; // R9

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            oper_q  <= uvt_pkg::UVT_OFF; // R7
            sonly_q <= uvt_pkg::SONLY_RST; // R8
            lpair_q <= uvt_pkg::LPAIR_RST; // R13
            start_q <= uvt_pkg::START_RST; // R4
            block_q <= uvt_pkg::BLOCK_RST; // R5
            ratio_q <= uvt_pkg::RATIO_RST; // R6
            delay_q <= uvt_pkg::DELAY_RST; // R9
            irq_mk_q <= '0;
        end else begin
            if (wr && hit_ctrl) begin
                oper_q  <= uvt_pkg::uvt_oper_t'(PWDATA[uvt_pkg::CTRL_OPER_LSB +: 2]); // R7
                sonly_q <= PWDATA[uvt_pkg::CTRL_SONLY]; // R8
                lpair_q <= PWDATA[uvt_pkg::CTRL_LPAIR]; // R13
            end
            if (wr && hit_lvl) begin
                start_q <= c_start;
                block_q <= c_block;
                ratio_q <= c_ratio;
            end
            if (wr && hit_dly) begin
                delay_q <= c_delay;
            end
            if (wr && hit_imk) begin
                irq_mk_q <= PWDATA[uvt_pkg::IRQ_W-1:0];
            end
        end
    end

    // ==========================================
    // Read data is latched in the setup cycle so it comes from a flop
    wire [31:0] rd_ctrl = {28'h0000000, lpair_q, sonly_q, oper_q};
    wire [31:0] rd_lvl  = {12'h000, ratio_q, block_q, start_q};
    wire [31:0] rd_dly  = {16'h0000, delay_q};
    wire [31:0] rd_stat = {26'h0000000, FUNCTION_BLOCK_IN, gtrip_q, gstart_q, ph_start};
    wire [31:0] rd_ist  = {30'h00000000, irq_st_q};
    wire [31:0] rd_imk  = {30'h00000000, irq_mk_q};
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                          hit_lvl  ? rd_lvl  :
                          hit_dly  ? rd_dly  :
                          hit_stat ? rd_stat :
                          hit_ist  ? rd_ist  :
                          hit_imk  ? rd_imk  : 32'h00000000;

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            rdata_q <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            rdata_q <= rd_mux;
        end
    end

    // ==========================================
    // Measuring elements
    assign cfg = '{oper: oper_q, start_only: sonly_q, line_pair: lpair_q, start_pct: start_q,
                   block_pct: block_q, ratio_pct: ratio_q, delay_ms: delay_q};
    assign mags[0] = PHASE_A_MAGNITUDE;
    assign mags[1] = PHASE_B_MAGNITUDE;
    assign mags[2] = PHASE_C_MAGNITUDE;

    // Disabled by the operation setting or the external block input
    wire enable = (oper_q != uvt_pkg::UVT_OFF) && !FUNCTION_BLOCK_IN; // R14 R17

    uvt_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk  (CLOCK),
        .rstn (RSTN),
        .tick (tick)
    );

    // Elements work on whatever the upstream stage supplies; LINE_PAIR_MODE tells it which
    for (genvar i = 0; i < 3; i++) begin : g_phase
        uvt_phase u_phase (
            .clk       (CLOCK),
            .rstn      (RSTN),
            .enable    (enable),
            .tick      (tick),
            .magnitude (mags[i]),
            .cfg       (cfg),
            .start_q   (ph_start[i]),
            .trip      (ph_trip[i])
        ); // R11
    end

    // ==========================================
    // Decision logic; phase trips never leave this module
    wire [1:0] n_trip = 2'(ph_trip[0]) + 2'(ph_trip[1]) + 2'(ph_trip[2]);

    always_comb begin
        case (oper_q)
            uvt_pkg::UVT_ONE: gtrip_d = n_trip >= 2'd1; // R15 R17
            uvt_pkg::UVT_TWO: gtrip_d = n_trip >= 2'd2; // R17
            uvt_pkg::UVT_ALL: gtrip_d = n_trip == 2'd3; // R17
            default:          gtrip_d = 1'b0; // R17
        endcase
    end

    assign gstart_d = enable && (|ph_start); // R2

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            gstart_q <= 1'b0;
            gtrip_q  <= 1'b0;
        end else begin
            gstart_q <= gstart_d;
            gtrip_q  <= gtrip_d && enable; // R12 R14
        end
    end

    // ==========================================
    // Interrupt: rising general start and trip; a new event beats a clear
    wire [uvt_pkg::IRQ_W-1:0] ev  = {gtrip_d && enable && !gtrip_q, gstart_d && !gstart_q};
    wire [uvt_pkg::IRQ_W-1:0] w1c = (wr && hit_ist) ? PWDATA[uvt_pkg::IRQ_W-1:0] : '0;

    assign irq_st_d = (irq_st_q & ~w1c) | ev;

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= irq_st_d;
        end
    end

    // ==========================================
    // Outputs
    assign PHASE_A_START     = ph_start[0]; // R1 R11
    assign PHASE_B_START     = ph_start[1];
    assign PHASE_C_START     = ph_start[2];
    assign GENERAL_START_OUT = gstart_q;
    assign GENERAL_TRIP_OUT  = gtrip_q; // R15
    assign LINE_PAIR_MODE    = lpair_q; // R13
    assign IRQ               = |(irq_st_q & irq_mk_q);

endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the undervoltage trip block
`timescale 1ns/1ps
module tb_top;
    localparam int T = 10;
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic [31:0] data;
        logic [31:0] exp;
        logic        err;
    } uvt_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [23:0] pct = 24'h646464;
    logic        blk = 1'b0;
    logic [15:0] mag_a;
    logic [15:0] mag_b;
    logic [15:0] mag_c;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  st;
    logic        gs;
    logic        gt;
    logic        lpm;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          n;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [3:0]  ops [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
    logic [1:0]  gen [5] = '{2'b00, 2'b11, 2'b11, 2'b10, 2'b10};
    uvt_row_t    rows [19] = '{
        '{8'h00, 1'b0, 32'h0, 32'h8, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h50a5a, 1'b0},
        '{8'h08, 1'b0, 32'h0, 32'h64, 1'b0}, '{8'h14, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h10, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h0c, 1'b1, 32'h3f, 32'h0, 1'b0},
        '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b1, 32'hf1e14, 32'h0, 1'b0},
        '{8'h04, 1'b0, 32'h0, 32'ha141e, 1'b0}, '{8'h04, 1'b1, 32'hff83, 32'h0, 1'b0},
        '{8'h04, 1'b0, 32'h0, 32'h11482, 1'b0}, '{8'h08, 1'b1, 32'hffff, 32'h0, 1'b0},
        '{8'h08, 1'b0, 32'h0, 32'hea60, 1'b0}, '{8'h08, 1'b1, 32'h31, 32'h0, 1'b0},
        '{8'h08, 1'b0, 32'h0, 32'h32, 1'b0}, '{8'h20, 1'b1, 32'h1, 32'h0, 1'b1},
        '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h00, 1'b1, 32'h0, 32'h0, 1'b0},
        '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}};

    uvt_src uvt_src_i (.pct(pct), .mag_a(mag_a), .mag_b(mag_b), .mag_c(mag_c));
    uvt_top #(.TICK_CYCLES(T)) uvt_top_i (
        .CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PHASE_A_MAGNITUDE(mag_a), .PHASE_B_MAGNITUDE(mag_b),
        .PHASE_C_MAGNITUDE(mag_c), .FUNCTION_BLOCK_IN(blk), .PHASE_A_START(st[0]),
        .PHASE_B_START(st[1]), .PHASE_C_START(st[2]), .GENERAL_START_OUT(gs),
        .GENERAL_TRIP_OUT(gt), .LINE_PAIR_MODE(lpm), .IRQ(irq));

    initial begin
        forever #10 clk = ~clk;
    end
    // ====
    // Shared tasks
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic ok;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        // A slave that never answers ends the run here
        if (!ok) begin
            mismatches++;
            print_verdict();
        end
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].data);
            if (!rows[i].wr) chk("rdata", rd, rows[i].exp);
            chk("slverr", 32'(er), 32'(rows[i].err));
        end
        chk("line_pair", 32'(lpm), 32'h0);
        $display("registers done");
        apb(1'b1, 8'h04, 32'h50a5a);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        pct[7:0] <= 8'd80;
        n = 0;
        while (gt !== 1'b1 && n < 60 * T) begin
            @(posedge clk);
            n++;
        end
        chk("trip_time", 32'(n >= 50 * T + 4 && n <= 51 * T + 3), 32'h1);
        chk("outputs", 32'({st, gs, gt, irq}), 32'hf);
        apb(1'b0, 8'h0c, 32'h0);
        chk("status", rd, 32'h19);
        apb(1'b0, 8'h10, 32'h0);
        chk("irq_status", rd, 32'h3);
        apb(1'b1, 8'h10, 32'h3);
        chk("irq_clear", 32'(irq), 32'h0);
        pct[7:0] <= 8'd92;
        repeat (5) @(posedge clk);
        chk("hold", 32'(st), 32'h1);
        pct[7:0] <= 8'd95;
        repeat (3) @(posedge clk);
        chk("drop", 32'({st, gs, gt}), 32'h0);
        pct[7:0] <= 8'd80;
        repeat (10) @(posedge clk);
        chk("restart", 32'({st, gt}), 32'h2);
        pct[7:0] <= 8'd0;
        repeat (3) @(posedge clk);
        chk("floor", 32'(st), 32'h0);
        pct[7:0] <= 8'd80;
        blk <= 1'b1;
        repeat (5) @(posedge clk);
        chk("blocked", 32'({st, gs, gt}), 32'h0);
        blk <= 1'b0;
        repeat (5) @(posedge clk);
        chk("unblocked", 32'(st), 32'h1);
        pct[7:0] <= 8'd100;
        $display("timing done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h00, 32'(ops[i]));
            pct[15:0] <= 16'h4650;
            repeat (53 * T) @(posedge clk);
            chk("general", 32'({gs, gt}), 32'(gen[i]));
            pct[15:0] <= 16'h6464;
            repeat (4) @(posedge clk);
        end
        $display("operation done");
        apb(1'b1, 8'h14, 32'h0);
        chk("masked", 32'(irq), 32'h0);
        apb(1'b1, 8'h14, 32'h2);
        chk("unmasked", 32'(irq), 32'h1);
        apb(1'b1, 8'h10, 32'h3);
        chk("cleared", 32'(irq), 32'h0);
        $display("interrupt done");
        apb(1'b1, 8'h00, 32'h1);
        pct[23:16] <= 8'd80;
        repeat (5) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("after_reset", 32'({st, gs, gt, irq, lpm}), 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", rd, 32'h8);
        $display("reset done");
        print_verdict();
    end
endmodule

// file: testbench/uvt_src.sv
// Upstream magnitude stage model for the undervoltage trip bench
`timescale 1ns/1ps
module uvt_src (
    input  wire logic [23:0] pct,
    output logic [15:0]      mag_a,
    output logic [15:0]      mag_b,
    output logic [15:0]      mag_c
);
    // ====
    // Magnitude scaling
    // Whole percents only: zero fraction bits keep expected levels exact
    assign mag_a = {pct[7:0], 8'h00};
    assign mag_b = {pct[15:8], 8'h00};
    assign mag_c = {pct[23:16], 8'h00};
endmodule

// file: testbench/uvt_top_sva.sv
// Port checker for the undervoltage trip block
`timescale 1ns/1ps
module uvt_top_sva #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic        CLOCK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [15:0] PHASE_A_MAGNITUDE,
    input wire logic        FUNCTION_BLOCK_IN,
    input wire logic        PHASE_A_START,
    input wire logic        PHASE_B_START,
    input wire logic        PHASE_C_START,
    input wire logic        GENERAL_START_OUT,
    input wire logic        GENERAL_TRIP_OUT,
    input wire logic        LINE_PAIR_MODE,
    input wire logic        IRQ
);
    // Shortest legal delay in clock cycles; a trip before it makes the check fire
    localparam int unsigned MIN_WAIT = 32'(uvt_pkg::DELAY_MIN) * TICK_CYCLES;
    logic [15:0] gs_cnt_q;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // ====
    // Start age counter
    // Saturates so a long start never wraps into a short one
    always_ff @(posedge CLOCK) begin
        if (!RSTN || !GENERAL_START_OUT) begin
            gs_cnt_q <= 16'h0000;
        end else if (gs_cnt_q != 16'hffff) begin
            gs_cnt_q <= gs_cnt_q + 16'h0001;
        end
    end
    // ====
    // Assertions
    chk_ready_always: assert property (PSEL && PENABLE |-> PREADY)
        else $error("no ready in access");
    chk_err_zero: assert property (PSEL && PENABLE && !PWRITE && PSLVERR |-> PRDATA == 32'h0)
        else $error("error read not zero");
    chk_gs_cause: assert property (GENERAL_START_OUT |->
        $past(PHASE_A_START || PHASE_B_START || PHASE_C_START))
        else $error("general start without phase");
    chk_block_off: assert property (FUNCTION_BLOCK_IN |=>
        !GENERAL_START_OUT && !GENERAL_TRIP_OUT) else $error("outputs while blocked");
    chk_start_range: assert property ($rose(PHASE_A_START) |->
        $past(PHASE_A_MAGNITUDE) < 16'h8200 && $past(PHASE_A_MAGNITUDE) != 16'h0)
        else $error("start outside level range");
    chk_zero_drop: assert property (PHASE_A_MAGNITUDE == 16'h0 |=> !PHASE_A_START)
        else $error("start at zero magnitude");
    chk_trip_time: assert property ($rose(GENERAL_TRIP_OUT) |-> gs_cnt_q >= MIN_WAIT)
        else $error("trip before delay");
    chk_reset_vals: assert property (@(posedge CLOCK) disable iff (1'b0)
        !RSTN |=> !GENERAL_TRIP_OUT && !GENERAL_START_OUT && !IRQ && LINE_PAIR_MODE)
        else $error("bad reset outputs");
    cover property ($rose(GENERAL_TRIP_OUT));
    cover property (PSEL && PENABLE && PSLVERR);
    cover property ($rose(IRQ));
endmodule
bind uvt_top uvt_top_sva #(.TICK_CYCLES(TICK_CYCLES)) uvt_top_sva_i (.*);
